/* File: hdl/pcd_pkg.sv */
/*
 * constants for the port change detect and configuration block:
 * register offsets, field positions, reset values, widths.
 * assumes nothing beyond a sv-2012 compiler.
 */
`default_nettype none
package pcd_pkg;
  // register offsets on the byte-wide command port
  localparam logic [7:0] OFF_DRIVE_LEVEL = 8'h02;
  localparam logic [7:0] OFF_CONTROL     = 8'h04;
  localparam logic [7:0] OFF_MASK        = 8'h06;
  localparam logic [7:0] OFF_DISP_TEST   = 8'h07;
  // control settings fields
  localparam int CTL_RUN_BIT   = 0;
  localparam int CTL_INDIV_BIT = 6;
  localparam int CTL_MON_BIT   = 7;
  // mask register: alert status in bit 7
  localparam int MASK_ALERT_BIT = 7;
  localparam int WATCH_W        = 7;
  // drive level code width
  localparam int CODE_W = 4;
  localparam int FRAC_W = 5;
  // display test enable bit
  localparam int TEST_BIT = 0;
  // reset values
  localparam logic [CODE_W-1:0]  RST_CODE = 4'h0;
  localparam logic [WATCH_W-1:0] RST_MASK = 7'h00;
  localparam logic [7:0]         RST_BYTE = 8'h00;
  // detector states, gray along idle -> armed -> flagged
  typedef enum logic [1:0] {
    DET_IDLE    = 2'b00,
    DET_ARMED   = 2'b01,
    DET_FLAGGED = 2'b11
  } det_state_t;
endpackage
`default_nettype wire

/* File: hdl/trans_if.sv */
/*
 * carrier between the register bank and the transition detector.
 * assumes both ends sit on the same clock.
 */
`default_nettype none
interface trans_if #(parameter int W = 7);
  logic [W-1:0] ports;     // synchronised watched port levels
  logic [W-1:0] mask;      // ports taking part in the compare
  logic         arm;       // control write with monitor bit set
  logic         disarm;    // control write with monitor bit clear
  logic         acc_clear; // any access of the mask register
  logic         armed;     // compare active
  logic         alert;     // sticky change alert
  logic [W-1:0] snapshot;  // comparison copy
  modport det (input ports, mask, arm, disarm, acc_clear,
               output armed, alert, snapshot);
  modport ctl (output ports, mask, arm, disarm, acc_clear,
               input armed, alert, snapshot);
endinterface
`default_nettype wire

/* File: hdl/trans_detect.sv */
/*
 * one-shot transition detector: snapshot, compare, sticky alert.
 * assumes port levels arrive already synchronised to mclk.
 */
`default_nettype none
module trans_detect #(
  parameter int W = 7
) (
  input  wire logic mclk,
  input  wire logic rst,
  trans_if.det      tif
);
  // whole state of the detector
  typedef struct packed {
    pcd_pkg::det_state_t st;
    logic [W-1:0]        snap;
  } det_t;

  det_t cur_reg;  // registered state
  det_t cur_next; // next state

  logic hit; // masked mismatch against the snapshot
  assign hit = |((tif.ports ^ cur_reg.snap) & tif.mask);

  // next state; arming outranks everything else
  always_comb begin
    cur_next = cur_reg;
    if (tif.arm) begin
      cur_next.snap = tif.ports;
      cur_next.st   = pcd_pkg::DET_ARMED;
    end else begin
      case (cur_reg.st)
        pcd_pkg::DET_ARMED: begin
          // any masked mismatch sets
          // set beats a same-cycle disarm write
          if (hit) begin
            cur_next.st = pcd_pkg::DET_FLAGGED;
          end else if (tif.disarm) begin
            cur_next.st = pcd_pkg::DET_IDLE;
          end
        end
        pcd_pkg::DET_FLAGGED: begin
          if (tif.acc_clear) begin
            cur_next.st = pcd_pkg::DET_IDLE;
          end
        end
        default: begin
          cur_next.st = pcd_pkg::DET_IDLE;
        end
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur_reg.st   <= pcd_pkg::DET_IDLE;
      cur_reg.snap <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign tif.armed    = (cur_reg.st == pcd_pkg::DET_ARMED);
  assign tif.alert    = (cur_reg.st == pcd_pkg::DET_FLAGGED);
  assign tif.snapshot = cur_reg.snap;
endmodule
`default_nettype wire

/* File: hdl/port_change_detect_config.sv */
/*
 * register bank of a serially controlled led driver and expander:
 * control settings, shared drive level, transition mask with
 * one-shot change alert, display test override.
 * assumes a byte-level command port from the two-wire front end
 * on mclk, and port configuration inputs on mclk. watched port
 * pins are asynchronous.
 */
// Function
// - control bit 0 selects shutdown or run
// - control bit 6 selects shared or individual current
// - control bit 7 enables monitoring, 5..1 unused
// - seven mask bits pick watched ports
// - ports watched whether input or output
// - monitor-enabled control write takes port snapshot
// - snapshot refreshes even when already enabled
// - armed until disarm write or detected change
// - arming drives alert bit and pin low
// - any masked mismatch sets the alert
// - alert drives alert-capable port high
// - alert stays set regardless of later levels
// - any mask register access clears alert
// - clearing disarms, stored enable bit unchanged
// - display test forces led ports without storing
// - display test leaves gpio outputs alone
// - display test uses half maximum current
// - shared level code n gives (n+1)/16
// - alert port as output follows alert
// - reset gives shutdown, global, disabled, minimum
`default_nettype none
module port_change_detect_config #(
  parameter int NUM_PORTS = 28
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_wdata,
  output var  logic [7:0]                  reg_rdata,
  output var  logic                        reg_rvalid,
  input  wire logic [pcd_pkg::WATCH_W-1:0] watched_ports,
  input  wire logic                        alert_port_is_out,
  input  wire logic [NUM_PORTS-1:0]        led_port_cfg,
  output var  logic                        normal_run,
  output var  logic                        individual_current,
  output var  logic [pcd_pkg::CODE_W-1:0]  global_code,
  output var  logic [pcd_pkg::FRAC_W-1:0]  global_fraction,
  output var  logic [NUM_PORTS-1:0]        test_led_force,
  output var  logic                        test_half_current,
  output var  logic                        alert_capable_port,
  output var  logic                        monitor_armed
);
  localparam int W = pcd_pkg::WATCH_W;

  // drive fraction numerator: code n gives n+1 sixteenths
  function automatic logic [pcd_pkg::FRAC_W-1:0] frac_of(
    input logic [pcd_pkg::CODE_W-1:0] code);
    frac_of = {1'b0, code} + 5'h01;
  endfunction

  // read-back byte for an offset; unused bits read zero
  function automatic logic [7:0] read_byte(
    input logic [7:0]                  a,
    input logic [pcd_pkg::CODE_W-1:0]  code,
    input logic                        run,
    input logic                        indiv,
    input logic                        mon,
    input logic                        alert,
    input logic [W-1:0]                msk,
    input logic                        tst);
    read_byte = 8'h00;
    if (a == pcd_pkg::OFF_DRIVE_LEVEL) begin
      read_byte[pcd_pkg::CODE_W-1:0] = code;
    end else if (a == pcd_pkg::OFF_CONTROL) begin
      read_byte[pcd_pkg::CTL_RUN_BIT]   = run;
      read_byte[pcd_pkg::CTL_INDIV_BIT] = indiv;
      read_byte[pcd_pkg::CTL_MON_BIT]   = mon;
    end else if (a == pcd_pkg::OFF_MASK) begin
      read_byte[W-1:0]                   = msk;
      read_byte[pcd_pkg::MASK_ALERT_BIT] = alert;
    end else if (a == pcd_pkg::OFF_DISP_TEST) begin
      read_byte[pcd_pkg::TEST_BIT] = tst;
    end
  endfunction

  // whole state of the bank
  typedef struct packed {
    logic [W-1:0]                sync1;  // first sync stage
    logic [W-1:0]                sync2;  // second sync stage
    logic                        run;    // control bit 0
    logic                        indiv;  // control bit 6
    logic                        mon;    // stored monitor bit
    logic [pcd_pkg::CODE_W-1:0]  code;   // shared drive level
    logic [W-1:0]                mask;   // watched port mask
    logic                        tst;    // display test
    logic [7:0]                  rdata;  // read answer
    logic                        rvalid; // read answer strobe
    logic                        alert_pin;
    logic [NUM_PORTS-1:0]        force_on;
    logic                        half;
  } bank_t;

  bank_t cur_reg;  // registered state
  bank_t cur_next; // next state

  trans_if #(.W(W)) tif ();

  // decoded strobes; a byte completes in one cycle
  logic wr_ctl;  // control settings write
  logic acc_msk; // mask register read or write

  assign wr_ctl  = reg_wr && (reg_addr == pcd_pkg::OFF_CONTROL);
  assign acc_msk = (reg_wr || reg_rd) &&
                   (reg_addr == pcd_pkg::OFF_MASK);

  // detector hookup; compare ignores port direction
  assign tif.ports     = cur_reg.sync2;
  assign tif.mask      = cur_reg.mask;
  assign tif.arm       = wr_ctl && reg_wdata[pcd_pkg::CTL_MON_BIT];
  assign tif.disarm    = wr_ctl && !reg_wdata[pcd_pkg::CTL_MON_BIT];
  assign tif.acc_clear = acc_msk;

  trans_detect #(.W(W)) u_det (
    .mclk (mclk),
    .rst  (rst),
    .tif  (tif)
  );

  // next state of the bank
  always_comb begin
    cur_next = cur_reg;
    // two flops before anything looks at the pins;
    // pulses shorter than a clock period may slip through
    cur_next.sync1  = watched_ports;
    cur_next.sync2  = cur_reg.sync1;
    cur_next.rvalid = 1'b0;
    if (reg_wr) begin
      if (reg_addr == pcd_pkg::OFF_DRIVE_LEVEL) begin
        cur_next.code = reg_wdata[pcd_pkg::CODE_W-1:0];
      end else if (reg_addr == pcd_pkg::OFF_CONTROL) begin
        cur_next.run   = reg_wdata[pcd_pkg::CTL_RUN_BIT];
        cur_next.indiv = reg_wdata[pcd_pkg::CTL_INDIV_BIT];
        cur_next.mon   = reg_wdata[pcd_pkg::CTL_MON_BIT];
      end else if (reg_addr == pcd_pkg::OFF_MASK) begin
        // mask bits; alert bit is read-only
        cur_next.mask = reg_wdata[W-1:0];
      end else if (reg_addr == pcd_pkg::OFF_DISP_TEST) begin
        cur_next.tst = reg_wdata[pcd_pkg::TEST_BIT];
      end
    end
    if (reg_rd) begin
      // alert sampled before the same access clears it
      cur_next.rdata  = read_byte(reg_addr, cur_reg.code,
                                  cur_reg.run, cur_reg.indiv,
                                  cur_reg.mon, tif.alert,
                                  cur_reg.mask, cur_reg.tst);
      cur_next.rvalid = 1'b1;
    end
    // pin follows alert only as output
    cur_next.alert_pin = alert_port_is_out && tif.alert;
    // only led-configured ports forced
    // stored port and control values are untouched
    cur_next.force_on = cur_reg.tst ? led_port_cfg : '0;
    cur_next.half = cur_reg.tst;
  end

  // state register; power-up defaults
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur_reg.sync1     <= '0;
      cur_reg.sync2     <= '0;
      cur_reg.run       <= 1'b0;
      cur_reg.indiv     <= 1'b0;
      cur_reg.mon       <= 1'b0;
      cur_reg.code      <= pcd_pkg::RST_CODE;
      cur_reg.mask      <= pcd_pkg::RST_MASK;
      cur_reg.tst       <= 1'b0;
      cur_reg.rdata     <= pcd_pkg::RST_BYTE;
      cur_reg.rvalid    <= 1'b0;
      cur_reg.alert_pin <= 1'b0;
      cur_reg.force_on  <= '0;
      cur_reg.half      <= 1'b0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // outputs from flops; global_fraction and monitor_armed decoded from them
  assign reg_rdata          = cur_reg.rdata;
  assign reg_rvalid         = cur_reg.rvalid;
  assign normal_run         = cur_reg.run;
  assign individual_current = cur_reg.indiv;
  assign global_code        = cur_reg.code;
  assign global_fraction    = frac_of(cur_reg.code);
  assign test_led_force     = cur_reg.force_on;
  assign test_half_current  = cur_reg.half;
  assign alert_capable_port = cur_reg.alert_pin;
  assign monitor_armed      = tif.armed;

  // control write lands next cycle
  run_bit_a: assert property (
    @(posedge mclk) disable iff (rst)
    wr_ctl |=> normal_run == $past(reg_wdata[pcd_pkg::CTL_RUN_BIT]))
    else $error("run bit not taken from control write");

  indiv_bit_a: assert property (
    @(posedge mclk) disable iff (rst)
    wr_ctl |=> individual_current == $past(reg_wdata[pcd_pkg::CTL_INDIV_BIT]))
    else $error("current mode bit not taken");

  ctl_read_a: assert property (
    @(posedge mclk) disable iff (rst)
    reg_rd && reg_addr == pcd_pkg::OFF_CONTROL
    |=> reg_rvalid && reg_rdata[5:1] == 5'h00)
    else $error("unused control bits not zero");

  snap_take_a: assert property (
    @(posedge mclk) disable iff (rst)
    tif.arm |=> monitor_armed && tif.snapshot == $past(tif.ports))
    else $error("snapshot not taken on arming write");

  arm_low_a: assert property (
    @(posedge mclk) disable iff (rst)
    tif.arm |=> !tif.alert ##1 !alert_capable_port)
    else $error("alert not low after arming");

  hit_set_a: assert property (
    @(posedge mclk) disable iff (rst)
    tif.armed && !tif.arm &&
    |((tif.ports ^ tif.snapshot) & tif.mask)
    |=> tif.alert)
    else $error("masked mismatch did not set alert");

  pin_follow_a: assert property (
    @(posedge mclk) disable iff (rst)
    tif.alert && alert_port_is_out |=> alert_capable_port)
    else $error("alert port not driven high");

  alert_hold_a: assert property (
    @(posedge mclk) disable iff (rst)
    tif.alert && !acc_msk && !tif.arm |=> tif.alert)
    else $error("alert dropped without mask access");

  read_clear_a: assert property (
    @(posedge mclk) disable iff (rst)
    tif.alert && reg_rd && acc_msk && !tif.arm
    |=> reg_rdata[7] && !tif.alert && !monitor_armed)
    else $error("mask read did not report then clear");

  test_force_a: assert property (
    @(posedge mclk) disable iff (rst)
    $past(cur_reg.tst) && $stable(led_port_cfg)
    |-> test_led_force == led_port_cfg && test_half_current)
    else $error("display test override wrong");

  frac_map_a: assert property (
    @(posedge mclk) disable iff (rst)
    global_fraction == {1'b0, global_code} + 5'h01)
    else $error("drive fraction mismatch");

  reset_dflt_a: assert property (
    @(posedge mclk) $past(rst)
    |-> !normal_run && !individual_current && !monitor_armed
        && global_code == pcd_pkg::RST_CODE)
    else $error("reset defaults wrong");

  level_take_a: assert property (
    @(posedge mclk) disable iff (rst)
    reg_wr && reg_addr == pcd_pkg::OFF_DRIVE_LEVEL
    |=> global_code == $past(reg_wdata[pcd_pkg::CODE_W-1:0]))
    else $error("drive level code not taken");

  mask_take_a: assert property (
    @(posedge mclk) disable iff (rst)
    reg_wr && acc_msk |=> tif.mask == $past(reg_wdata[W-1:0]))
    else $error("mask bits not taken from write");

  disarm_a: assert property (
    @(posedge mclk) disable iff (rst)
    tif.armed && tif.disarm && !(|((tif.ports ^ tif.snapshot) & tif.mask))
    |=> !monitor_armed && !tif.alert)
    else $error("disarm write left monitor active");

  one_shot_a: assert property (
    @(posedge mclk) disable iff (rst)
    !tif.armed && !tif.alert && !tif.arm |=> !tif.alert && !monitor_armed)
    else $error("alert raised while not armed");

  mon_kept_a: assert property (
    @(posedge mclk) disable iff (rst)
    acc_msk && !wr_ctl |=> cur_reg.mon == $past(cur_reg.mon))
    else $error("mask access changed stored monitor bit");

  pin_quiet_a: assert property (
    @(posedge mclk) disable iff (rst)
    !alert_port_is_out |=> !alert_capable_port)
    else $error("alert port driven while not an output");

  gpio_keep_a: assert property (
    @(posedge mclk) disable iff (rst)
    (test_led_force & ~$past(led_port_cfg)) == '0)
    else $error("display test forced a non-led port");
endmodule
`default_nettype wire

/* File: bench/host_model.sv */
/*
 * host model: bus master that writes and reads the register bank
 * one byte per access.
 * assumes the byte-level command port runs on mclk.
 */
`default_nettype none
module host_model (
  input  wire logic       mclk,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle port at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // byte write pulse
  // lines are scrambled after the pulse so nothing stale looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
/*
 * self-checking bench for the register bank and change detector.
 * assumes host_model drives the register port; pins come from here.
 */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst;              // clock, sync reset
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, reg_rvalid;
  logic [6:0]  watched_ports;          // async pin levels
  logic        alert_port_is_out;      // alert pin as output
  logic [27:0] led_port_cfg;           // led driver ports
  logic        normal_run, individual_current, test_half_current;
  logic        alert_capable_port, monitor_armed;
  logic [3:0]  global_code;
  logic [4:0]  global_fraction;
  logic [27:0] test_led_force;
  logic [7:0]  exp_q[$];               // expected read bytes, oldest first
  logic [7:0]  offs[4] = '{8'h02, 8'h04, 8'h06, 8'h07};
  logic [7:0]  r;                      // random scratch
  int          errors = 0;
  int          n_tests = 0;

  host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
                   .reg_wdata(reg_wdata));
  port_change_detect_config #(.NUM_PORTS(28)) dut (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .watched_ports(watched_ports), .alert_port_is_out(alert_port_is_out),
    .led_port_cfg(led_port_cfg), .normal_run(normal_run),
    .individual_current(individual_current), .global_code(global_code),
    .global_fraction(global_fraction), .test_led_force(test_led_force),
    .test_half_current(test_half_current), .alert_capable_port(alert_capable_port),
    .monitor_armed(monitor_armed));

  // 50 mhz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // counted compare, four-state exact
  task automatic check(input logic [31:0] got, input logic [31:0] e, input string m);
    n_tests++;
    if (got !== e) begin
      errors++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, m, got, e);
    end
  endtask

  // read answers are matched against the oldest note
  always @(posedge mclk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("unexpected at %0t: read answer with no request", $time);
      end else begin
        check(reg_rdata, exp_q.pop_front(), "read data");
      end
    end
  end

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  // write, then step past the edge so its effects have landed
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    #1;
  endtask

  // new pin levels at an edge, then n more edges
  task automatic pins(input logic [6:0] v, input int n);
    @(posedge mclk);
    watched_ports <= v;
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // bounded wait for the alert pin to rise
  task automatic wait_alert(input string m);
    repeat (8) begin
      if (alert_capable_port === 1'b1) break;
      @(posedge mclk);
      #1;
    end
    check(alert_capable_port, 1'b1, m);
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial begin
    void'($urandom(17624));
    rst = 1'b1;
    watched_ports = 7'h00;
    alert_port_is_out = 1'b0;
    led_port_cfg = 28'h0000000;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check({normal_run, individual_current, monitor_armed, test_half_current}, 0, "rst");
    check({global_code, global_fraction}, 9'h001, "rst code");
    foreach (offs[i]) rdx(offs[i], 8'h00);
    for (int n = 0; n < 16; n++) begin
      r = 8'($urandom);
      wrc(pcd_pkg::OFF_DRIVE_LEVEL, {r[7:4], n[3:0]});
      check({global_code, global_fraction}, {n[3:0], 5'(n + 1)}, "level");
      rdx(pcd_pkg::OFF_DRIVE_LEVEL, {4'h0, n[3:0]});
    end
    r = 8'($urandom);
    wrc(pcd_pkg::OFF_CONTROL, {2'b01, r[5:1], 1'b1});
    check({normal_run, individual_current, monitor_armed}, 3'b110, "control");
    rdx(pcd_pkg::OFF_CONTROL, 8'h41);
    wrc(pcd_pkg::OFF_CONTROL, 8'h00);
    check({normal_run, individual_current}, 2'b00, "global mode");
    rdx(8'h03, 8'h00);
    wrc(8'h05, 8'hff);
    rdx(pcd_pkg::OFF_CONTROL, 8'h00);
    // mask and alert pin set before arming
    @(posedge mclk);
    alert_port_is_out <= 1'b1;
    r = 8'($urandom);
    pins(r[6:0], 1);
    wrc(pcd_pkg::OFF_MASK, 8'h85);
    wrc(pcd_pkg::OFF_CONTROL, 8'h81);
    check({monitor_armed, alert_capable_port}, 2'b10, "armed");
    pins(r[6:0] ^ 7'h7a, 8);
    check(alert_capable_port, 1'b0, "masked bits");
    pins(r[6:0] ^ 7'h7e, 2);
    pins(r[6:0] ^ 7'h7a, 0);
    wait_alert("pulse alert");
    pins(r[6:0], 8);
    check(alert_capable_port, 1'b1, "sticky");
    rdx(pcd_pkg::OFF_MASK, 8'h85);
    rdx(pcd_pkg::OFF_MASK, 8'h05);
    pins(r[6:0] ^ 7'h01, 8);
    check({monitor_armed, alert_capable_port}, 2'b00, "one shot");
    rdx(pcd_pkg::OFF_CONTROL, 8'h81);
    wrc(pcd_pkg::OFF_CONTROL, 8'h81);
    pins(r[6:0] ^ 7'h01, 8);
    check({monitor_armed, alert_capable_port}, 2'b10, "fresh snapshot");
    @(posedge mclk);
    alert_port_is_out <= 1'b0;
    pins(r[6:0], 8);
    check(alert_capable_port, 1'b0, "pin not output");
    rdx(pcd_pkg::OFF_MASK, 8'h85);
    @(posedge mclk);
    alert_port_is_out <= 1'b1;
    wrc(pcd_pkg::OFF_CONTROL, 8'h81);
    pins(r[6:0] ^ 7'h04, 0);
    wait_alert("alert pin");
    wrc(pcd_pkg::OFF_MASK, 8'h05);
    pins(r[6:0] ^ 7'h04, 3);
    check(alert_capable_port, 1'b0, "write clears");
    rdx(pcd_pkg::OFF_MASK, 8'h05);
    wrc(pcd_pkg::OFF_CONTROL, 8'h81);
    wrc(pcd_pkg::OFF_CONTROL, 8'h01);
    pins(r[6:0], 8);
    check({monitor_armed, alert_capable_port}, 2'b00, "disarm");
    @(posedge mclk);
    led_port_cfg <= 28'($urandom);
    wrc(pcd_pkg::OFF_DISP_TEST, 8'h01);
    // override is registered one edge after the stored test bit
    @(posedge mclk);
    #1;
    check(test_led_force, led_port_cfg, "led force");
    check({test_half_current, global_code}, 5'h1f, "half current");
    rdx(pcd_pkg::OFF_DRIVE_LEVEL, 8'h0f);
    wrc(pcd_pkg::OFF_DISP_TEST, 8'h00);
    @(posedge mclk);
    #1;
    check(test_led_force, 28'h0000000, "test off");
    wrc(pcd_pkg::OFF_CONTROL, 8'h81);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    check({normal_run, individual_current, monitor_armed, test_half_current}, 0, "rerun");
    check({global_code, global_fraction, alert_capable_port}, 10'h002, "rerun code");
    rdx(pcd_pkg::OFF_MASK, 8'h00);
    rdx(pcd_pkg::OFF_CONTROL, 8'h00);
    repeat (4) @(posedge mclk);
    check(exp_q.size(), 0, "reads answered");
    results();
  end

  // watchdog: the run needs only a few microseconds
  initial begin
    #100us;
    errors++;
    $display("unexpected at %0t: run hung", $time);
    results();
  end
endmodule
`default_nettype wire
